// file: rtl/pwr_seq_pkg.sv
// Purpose: Shared constants and types for the power sense reset sequencer
// Assumes: 100 MHz clk, synchronous active-high reset
// Notes:   Times kept in their own units, cycle counts derived here
package pwr_seq_pkg;

  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned ASSERT_DELAY_NS = 5000;
  localparam int unsigned ASSERT_DELAY_CY = (ASSERT_DELAY_NS * CLK_MHZ) / 1000;
  localparam int unsigned MIN_ACTIVE_US   = 2000;
  localparam int unsigned MIN_ACTIVE_CY   = MIN_ACTIVE_US * CLK_MHZ;
  localparam int unsigned QUAL_TIME_NS    = 1000;
  localparam int unsigned QUAL_TIME_CY    = (QUAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned SYNC_STAGES     = 2;

  typedef enum logic [2:0] {
    ST_POWER_OFF,
    ST_WAIT_FW,
    ST_RUN,
    ST_DELAY,
    ST_PARK,
    ST_HOLD
  } seq_state_t;

  // Firmware side request and answer group
  typedef struct packed {
    logic release_general;
    logic release_controller;
    logic internal_reset;
    logic ctrl_reset_on_loss;
    logic park_done;
  } fw_ctrl_t;

  typedef struct packed {
    logic park_req;
    logic running;
    logic pg_qualified;
  } seq_status_t;

endpackage : pwr_seq_pkg

// file: rtl/input_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous level
// Assumes: Input may change at any time
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module input_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  import pwr_seq_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state       = state;
    next_state.stage = {state.stage[SYNC_STAGES-2:0], async_in};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage[SYNC_STAGES-1];

endmodule : input_sync

// file: rtl/power_sense_reset_sequencer.sv
// Purpose: Drive general and controller reset outputs from power sense inputs
// Assumes: power_on_sense and power_good_in come from an external monitor
// Notes:   Firmware release and park handshake are plain ports
`timescale 1ns/1ps
module power_sense_reset_sequencer #(
  parameter int unsigned MIN_HOLD_CY = pwr_seq_pkg::MIN_ACTIVE_CY
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   power_on_sense,
  input  wire logic                   power_good_in,
  input  wire pwr_seq_pkg::fw_ctrl_t  fw_ctrl,
  output logic                        general_reset_out_n,
  output logic                        controller_reset_out_n,
  output pwr_seq_pkg::seq_status_t    status
);
  import pwr_seq_pkg::*;

  // ************************************************
  // Input synchronisers
  // ************************************************
  logic pos_sync;
  logic pg_sync;

  input_sync u_sync_pos (
    .clk      (clk),
    .reset    (reset),
    .async_in (power_on_sense),
    .sync_out (pos_sync)
  );

  input_sync u_sync_pg (
    .clk      (clk),
    .reset    (reset),
    .async_in (power_good_in),
    .sync_out (pg_sync)
  );

  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    seq_state_t       st;
    logic [CNT_W-1:0] qual_cnt;
    logic             pg_ok;
    logic [CNT_W-1:0] delay_cnt;
    logic [CNT_W-1:0] gen_cnt;
    logic [CNT_W-1:0] ctl_cnt;
    logic             gen_n;
    logic             ctl_n;
    logic             ctl_on_loss;
    logic             park_req;
    logic             running;
  } seq_regs_t;

  seq_regs_t r;
  seq_regs_t next_r;

  localparam logic [CNT_W-1:0] QUAL_LAST  = CNT_W'(QUAL_TIME_CY - 1);
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(ASSERT_DELAY_CY - 1);
  // Hold length is a parameter so a bench can shorten it
  localparam logic [CNT_W-1:0] MIN_LAST   = CNT_W'(MIN_HOLD_CY - 1);

  logic gen_min_done;
  logic ctl_min_done;

  always_comb begin
    next_r = r;
    gen_min_done = (r.gen_cnt >= MIN_LAST);
    ctl_min_done = (r.ctl_cnt >= MIN_LAST);

    // Qualification counter restarts on any low sample
    if (!pg_sync) begin
      next_r.qual_cnt = '0;
      next_r.pg_ok    = 1'b0;
    end else if (!r.pg_ok) begin
      if (r.qual_cnt == QUAL_LAST) begin
        next_r.pg_ok = 1'b1;
      end else begin
        next_r.qual_cnt = r.qual_cnt + 1'b1;
      end
    end

    // Minimum active time counters run while each output is low
    if (!r.gen_n && !gen_min_done) begin
      next_r.gen_cnt = r.gen_cnt + 1'b1;
    end
    if (!r.ctl_n && !ctl_min_done) begin
      next_r.ctl_cnt = r.ctl_cnt + 1'b1;
    end

    unique case (r.st)
      ST_POWER_OFF: begin
        next_r.gen_n = 1'b0;
        next_r.ctl_n = 1'b0;
        if (pos_sync) begin
          next_r.st = ST_WAIT_FW;
        end
      end
      ST_WAIT_FW: begin
        // Firmware may release each output once its hold time is met
        if (fw_ctrl.release_general && gen_min_done && r.pg_ok) begin
          next_r.gen_n = 1'b1;
        end
        if (fw_ctrl.release_controller && ctl_min_done && r.pg_ok) begin
          next_r.ctl_n = 1'b1;
        end
        if (r.gen_n && r.ctl_n && r.pg_ok) begin
          next_r.st = ST_RUN;
        end
        if (fw_ctrl.internal_reset) begin
          next_r.st          = ST_DELAY;
          next_r.delay_cnt   = '0;
          next_r.ctl_on_loss = fw_ctrl.ctrl_reset_on_loss;
        end
      end
      ST_RUN: begin
        // Any loss of qualification parks, a short dip as well
        if (!r.pg_ok) begin
          next_r.st        = ST_PARK;
          next_r.park_req  = 1'b1;
          next_r.ctl_on_loss = fw_ctrl.ctrl_reset_on_loss;
        end else if (fw_ctrl.internal_reset) begin
          next_r.st          = ST_DELAY;
          next_r.delay_cnt   = '0;
          next_r.ctl_on_loss = fw_ctrl.ctrl_reset_on_loss;
        end
      end
      ST_PARK: begin
        // Reset waits for the park so mirrors settle before supplies drop
        if (fw_ctrl.park_done) begin
          next_r.park_req  = 1'b0;
          next_r.st        = ST_DELAY;
          next_r.delay_cnt = '0;
        end
      end
      ST_DELAY: begin
        if (r.delay_cnt == DELAY_LAST) begin
          next_r.gen_n   = 1'b0;
          next_r.gen_cnt = '0;
          if (r.ctl_on_loss) begin
            next_r.ctl_n   = 1'b0;
            next_r.ctl_cnt = '0;
          end
          next_r.st = ST_WAIT_FW;
        end else begin
          next_r.delay_cnt = r.delay_cnt + 1'b1;
        end
      end
      ST_HOLD: begin
        next_r.st = ST_WAIT_FW;
      end
      default: begin
        next_r.st = ST_POWER_OFF;
      end
    endcase

    // Power-on sense low overrides everything at once
    if (!pos_sync) begin
      next_r.st       = ST_POWER_OFF;
      next_r.park_req = 1'b0;
      if (r.gen_n) begin
        next_r.gen_cnt = '0;
      end
      if (r.ctl_n) begin
        next_r.ctl_cnt = '0;
      end
      next_r.gen_n = 1'b0;
      next_r.ctl_n = 1'b0;
    end

    // Registered so the running flag leaves a flop
    next_r.running = (next_r.st == ST_RUN);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r             <= '0;
      r.st          <= ST_POWER_OFF;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign general_reset_out_n    = r.gen_n;
  assign controller_reset_out_n = r.ctl_n;
  assign status = '{park_req:     r.park_req,
                    running:      r.running,
                    pg_qualified: r.pg_ok};

  // ************************************************
  // Assertions
  // ************************************************
  a_gen_low_off: assert property (@(posedge clk) disable iff (reset)
    !pos_sync |=> !general_reset_out_n)
    else $error("general reset not low while sense low");

  a_ctl_low_off: assert property (@(posedge clk) disable iff (reset)
    !pos_sync |=> !controller_reset_out_n)
    else $error("controller reset not low while sense low");

  a_gen_fw_rel: assert property (@(posedge clk) disable iff (reset)
    $rose(general_reset_out_n) |-> $past(fw_ctrl.release_general))
    else $error("general reset released without firmware");

  a_ctl_fw_rel: assert property (@(posedge clk) disable iff (reset)
    $rose(controller_reset_out_n) |-> $past(fw_ctrl.release_controller))
    else $error("controller reset released without firmware");

  a_gen_min_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(general_reset_out_n) |-> $past(gen_min_done))
    else $error("general reset shorter than minimum");

  a_ctl_min_hold: assert property (@(posedge clk) disable iff (reset)
    $rose(controller_reset_out_n) |-> $past(ctl_min_done))
    else $error("controller reset shorter than minimum");

  a_loss_delay: assert property (@(posedge clk) disable iff (reset)
    (r.st == ST_DELAY && r.delay_cnt == '0 && pos_sync) ##0 (pos_sync [*8])
    |-> general_reset_out_n == $past(general_reset_out_n, 7))
    else $error("general reset asserted before delay");

  a_park_first: assert property (@(posedge clk) disable iff (reset)
    $fell(general_reset_out_n) && pos_sync |-> !status.park_req)
    else $error("reset asserted while park pending");

  a_run_pg: assert property (@(posedge clk) disable iff (reset)
    status.running |-> $past(r.pg_ok))
    else $error("running without qualified power good");

  a_pg_qual: assert property (@(posedge clk) disable iff (reset)
    $rose(r.pg_ok) |-> $past(pg_sync, 1) && $past(pg_sync, 2))
    else $error("power good qualified too early");

  a_ctl_opt: assert property (@(posedge clk) disable iff (reset)
    (r.st == ST_DELAY && r.delay_cnt == DELAY_LAST && !r.ctl_on_loss && pos_sync
     && controller_reset_out_n) |=> controller_reset_out_n)
    else $error("controller reset asserted without option");

  a_park_on_loss: assert property (@(posedge clk) disable iff (reset)
    status.running && !status.pg_qualified && pos_sync |=> status.park_req)
    else $error("no park request after power good loss");

  a_park_hold: assert property (@(posedge clk) disable iff (reset)
    status.park_req && pos_sync |=> $stable(general_reset_out_n))
    else $error("general reset moved during park");

  a_gen_pg_low: assert property (@(posedge clk) disable iff (reset)
    !status.pg_qualified && !general_reset_out_n |=> !general_reset_out_n)
    else $error("general reset released while power good low");

  a_ctl_pg_low: assert property (@(posedge clk) disable iff (reset)
    !status.pg_qualified && !controller_reset_out_n |=> !controller_reset_out_n)
    else $error("controller reset released while power good low");

  a_gen_rel_pg: assert property (@(posedge clk) disable iff (reset)
    $rose(general_reset_out_n) |-> $past(status.pg_qualified))
    else $error("general reset released before qualification");

  a_pg_drop: assert property (@(posedge clk) disable iff (reset)
    !pg_sync |=> !status.pg_qualified)
    else $error("qualification kept after low sample");

  a_sync_pos: assert property (@(posedge clk) disable iff (reset)
    $changed(pos_sync) && !$past(reset) && !$past(reset, 2)
    |-> pos_sync == $past(power_on_sense, 2))
    else $error("sense sync path not two stages");

  a_sync_pg: assert property (@(posedge clk) disable iff (reset)
    $changed(pg_sync) && !$past(reset) && !$past(reset, 2)
    |-> pg_sync == $past(power_good_in, 2))
    else $error("power good sync path not two stages");

  a_ctl_on_loss: assert property (@(posedge clk) disable iff (reset)
    $fell(general_reset_out_n) && pos_sync && r.ctl_on_loss |-> !controller_reset_out_n)
    else $error("controller reset missed with option set");

  // ************************************************
  // Cover points
  // ************************************************
  c_power_up: cover property (@(posedge clk) disable iff (reset) $rose(status.running));
  c_park_seq: cover property (@(posedge clk) disable iff (reset) $rose(status.park_req));
  c_int_reset: cover property (@(posedge clk) disable iff (reset)
    $fell(general_reset_out_n) && pos_sync);
  c_loss_ctl: cover property (@(posedge clk) disable iff (reset)
    $fell(controller_reset_out_n) && pos_sync);
  c_sense_drop: cover property (@(posedge clk) disable iff (reset) $fell(pos_sync));

endmodule : power_sense_reset_sequencer

// file: verif/supply_monitor.sv
// Purpose: Behavioural external supply monitor driving the two sense levels
// Assumes: Levels change just after a falling clock edge
// Notes:   drop_sense is a deliberate fault, used only by one scenario
`timescale 1ns/1ps
module supply_monitor (
  input  wire logic clk,
  output logic      power_on_sense,
  output logic      power_good_in
);
  // ****************************************
  // Monitor actions
  // ****************************************
  initial begin
    power_on_sense = 1'b0;
    power_good_in  = 1'b0;
  end

  // Supplies up first, power good follows later
  task ramp_up;
    @(negedge clk);
    power_good_in  = 1'b0;
    power_on_sense = 1'b1;
    repeat (10) @(negedge clk);
    power_good_in = 1'b1;
  endtask : ramp_up

  // Early warning: sense held high through the interval
  task warn_loss;
    @(negedge clk);
    power_good_in  = 1'b0;
    power_on_sense = 1'b1;
  endtask : warn_loss

  // Short high pulse, too brief to qualify
  task glitch_pg(input int len);
    @(negedge clk);
    power_good_in = 1'b1;
    repeat (len) @(negedge clk);
    power_good_in = 1'b0;
  endtask : glitch_pg

  // Fault: sense drops while power good is still high
  task drop_sense;
    @(negedge clk);
    power_on_sense = 1'b0;
  endtask : drop_sense
endmodule : supply_monitor

// file: verif/tb.sv
// Purpose: Self-checking bench for the power sense reset sequencer
// Assumes: Hold shortened through a parameter so the run stays brief
// Notes:   Inputs change at falling edges; outputs sampled there too
`timescale 1ns/1ps
module tb;
  import pwr_seq_pkg::*;
  logic        clk         = 1'b0;
  logic        reset       = 1'b1;
  fw_ctrl_t    fw          = '0;
  logic        pos_s;
  logic        pg_s;
  logic        gen_n;
  logic        ctl_n;
  seq_status_t st;
  int          n_fail      = 0;
  int          check_count = 0;
  int          n;

  // Full hold would cost 200000 cycles per release
  localparam int unsigned HOLD_CY = 2000;

  always #5 clk = ~clk;

  supply_monitor i_mon (.clk(clk), .power_on_sense(pos_s), .power_good_in(pg_s));
  power_sense_reset_sequencer #(.MIN_HOLD_CY(HOLD_CY)) i_dut (.clk(clk), .reset(reset),
    .power_on_sense(pos_s),
    .power_good_in(pg_s), .fw_ctrl(fw), .general_reset_out_n(gen_n),
    .controller_reset_out_n(ctl_n), .status(st));

  // ****************************************
  // Shared helpers
  // ****************************************
  function automatic logic pick(input int idx);
    case (idx)
      0: pick = gen_n;
      1: pick = ctl_n;
      2: pick = st.park_req;
      3: pick = st.running;
      default: pick = st.pg_qualified;
    endcase
  endfunction : pick

  task automatic wait_for(input int idx, input logic val, input int maxc, output int cnt);
    cnt = 0;
    while (pick(idx) !== val && cnt < maxc) begin
      @(negedge clk);
      cnt++;
    end
    if (pick(idx) !== val) chk("wait limit", val, pick(idx));
  endtask : wait_for

  task automatic chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task tally_and_finish;
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Scenarios
  // ****************************************
  task s_power_up;
    fw.release_general    = 1'b0;
    fw.release_controller = 1'b0;
    i_mon.ramp_up();
    wait_for(4, 1'b1, 130, n);
    chk("pg qualify time", 1'b1, n >= 95 && n <= 106 && st.pg_qualified === 1'b1);
    fw.release_general = 1'b1;
    repeat (20) @(negedge clk);
    chk("general held early", 1'b0, gen_n);
    wait_for(0, 1'b1, HOLD_CY, n);
    chk("general released", 1'b1, gen_n);
    chk("controller awaits fw", 1'b0, ctl_n);
    fw.release_controller = 1'b1;
    wait_for(3, 1'b1, 4, n);
    chk("controller released", 1'b1, ctl_n);
    chk("running", 1'b1, st.running);
  endtask : s_power_up

  task s_internal;
    fw.ctrl_reset_on_loss = 1'b0;
    fw.internal_reset     = 1'b1;
    @(negedge clk);
    fw.internal_reset = 1'b0;
    wait_for(0, 1'b0, 600, n);
    chk("internal delay", 1'b1, n >= 494 && n <= 506 && gen_n === 1'b0);
    chk("controller kept", 1'b1, ctl_n);
    wait_for(0, 1'b1, HOLD_CY + 20, n);
    chk("min active", 1'b1, n >= HOLD_CY - 2 && gen_n === 1'b1);
  endtask : s_internal

  task s_sense_drop;
    i_mon.drop_sense();
    wait_for(0, 1'b0, 4, n);
    chk("general on sense low", 1'b0, gen_n);
    chk("controller on sense low", 1'b0, ctl_n);
    repeat (300) @(negedge clk);
    chk("general stays low", 1'b0, gen_n);
    chk("controller stays low", 1'b0, ctl_n);
  endtask : s_sense_drop

  task s_loss;
    fw.ctrl_reset_on_loss = 1'b1;
    i_mon.warn_loss();
    wait_for(2, 1'b1, 8, n);
    chk("park request", 1'b1, st.park_req);
    chk("pg unqualified", 1'b0, st.pg_qualified);
    repeat (50) @(negedge clk);
    chk("no reset before park", 1'b1, gen_n);
    fw.park_done = 1'b1;
    @(negedge clk);
    fw.park_done = 1'b0;
    wait_for(0, 1'b0, 600, n);
    chk("loss delay", 1'b1, n >= 494 && n <= 506 && gen_n === 1'b0);
    chk("controller on loss", 1'b0, ctl_n);
    i_mon.glitch_pg(50);
    repeat (10) @(negedge clk);
    chk("glitch ignored", 1'b0, st.pg_qualified);
    repeat (HOLD_CY + 200) @(negedge clk);
    chk("held while pg low", 1'b0, gen_n);
  endtask : s_loss

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) @(negedge clk);
    chk("general in reset", 1'b0, gen_n);
    chk("controller in reset", 1'b0, ctl_n);
    chk("status in reset", 1'b0, |st);
    reset = 1'b0;
    s_power_up();
    s_internal();
    s_sense_drop();
    s_power_up();
    s_loss();
    tally_and_finish();
  end

  // Four shortened holds plus generous margin
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule : tb
